// [hw/efsc_core.sv]
// FIFO service logic of an extended parallel port: host port, DMA, interrupts.
// Assumes a single 250 MHz clock; the peripheral, dack and tc pins are asynchronous to it, the host port inputs are not.
`timescale 1ns/10ps
`default_nettype none

module efsc_core (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic [efsc_pkg::AW-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  input  wire logic                   i_dack_n,
  input  wire logic                   i_tc,
  output logic                        o_drq,
  output logic                        o_irq_o,
  output logic                        o_irq_oe,
  input  wire logic                   i_fault_n,
  input  wire logic                   i_ack_n,
  output logic      [3:0]             o_ctl_o,
  output logic      [3:0]             o_ctl_oe,
  output logic      [7:0]             o_tx_data,
  output logic                        o_tx_cmd,
  output logic                        o_tx_stb,
  input  wire logic                   i_tx_busy,
  input  wire logic                   i_rx_stb,
  input  wire logic                   i_rx_cmd,
  input  wire logic [7:0]             i_rx_data
);
  import efsc_pkg::*;

  // ***********************
  // Pin synchronisers
  // ***********************
  // Data pins are sampled beside their strobe; the peripheral must hold
  // them stable before the strobe edge, so a shared two-stage chain is enough.
  logic [14:0] pin_a_r, pin_b_r, pin_c_r;
  wire  [14:0] pins_in = {i_rx_data, i_rx_cmd, i_rx_stb, i_tx_busy,
                          i_ack_n, i_fault_n, i_tc, i_dack_n};
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_a_r <= 15'h7FFF;
      pin_b_r <= 15'h7FFF;
      pin_c_r <= 15'h7FFF;
    end else begin
      pin_a_r <= pins_in;
      pin_b_r <= pin_a_r;
      pin_c_r <= pin_b_r;
    end
  end
  wire       dack    = ~pin_b_r[0];
  wire       tc      = pin_b_r[1];
  wire       fault   = ~pin_b_r[2];
  wire       fault_f = pin_c_r[2] & ~pin_b_r[2];
  wire       ack_r   = ~pin_c_r[3] & pin_b_r[3];
  wire       busy    = pin_b_r[4];
  wire       rx_edge = pin_b_r[5] & ~pin_c_r[5];
  wire       rx_cmd  = pin_b_r[6];
  wire [7:0] rx_data = pin_b_r[14:7];

  // ***********************
  // Control registers
  // ***********************
  logic [2:0] mode_r;
  logic       svc_r, dma_en_r, errl_r, dir_r, acken_r;
  logic [3:0] thr_r, pins_r;
  logic [4:0] cnt_r;
  wire        wr_reg  = i_wr & ~dack;
  wire        wr_ecr  = wr_reg & (i_addr == OFS_ECR);
  wire        wr_cfg  = wr_reg & (i_addr == OFS_CFG);
  wire        tc_ev   = tc & dack & dma_en_r & ~svc_r;
  wire        auto_md = (mode_r == MODE_FIFO) | (mode_r == MODE_ECP);
  wire        fifo_md = auto_md | (mode_r == MODE_TEST);
  wire        full    = (cnt_r == DEPTH_C);
  wire        empty   = (cnt_r == 5'h00);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r   <= MODE_STD;
      svc_r    <= 1'b1;
      dma_en_r <= 1'b0;
      errl_r   <= 1'b1;
      dir_r    <= 1'b0;
      acken_r  <= 1'b0;
      thr_r    <= THR_RST;
      pins_r   <= PINS_RST;
    end else begin
      if (wr_ecr) begin
        mode_r   <= i_wdata[ECR_MODE +: 3];
        dma_en_r <= i_wdata[ECR_DMA];
        errl_r   <= i_wdata[ECR_ERRL];
      end
      if (tc_ev) begin
        svc_r <= 1'b1;
      end else if (wr_ecr) begin
        svc_r <= i_wdata[ECR_SVC];
      end
      if (wr_cfg) begin
        thr_r   <= i_wdata[3:0];
        dir_r   <= i_wdata[CFG_DIR];
        acken_r <= i_wdata[CFG_ACKEN];
      end
      if (wr_reg && (i_addr == OFS_PINS)) begin
        pins_r <= i_wdata[3:0];
      end
    end
  end

  // ***********************
  // Thresholds
  // ***********************
  // field plus one
  wire [4:0] thr_eff = {1'b0, thr_r} + 5'h01;
  wire [4:0] thr_use = (thr_eff == DEPTH_C) ? THR_CAP : thr_eff;
  wire [4:0] lvl     = DEPTH_C - thr_use;
  wire [4:0] free    = DEPTH_C - cnt_r;

  // ***********************
  // Shared FIFO and expansion
  // ***********************
  logic [8:0] mem_r [DEPTH];
  logic [3:0] wp_r, rp_r;
  logic [6:0] rle_n_r;
  logic       rle_p_r;
  logic [7:0] rep_n_r, rep_b_r;
  efsc_tx_t   tx_st_r;

  wire dma_wr  = i_wr & dack;
  wire dma_rd  = i_rd & dack;
  wire h_dwr   = dma_wr | (i_wr & ~dack & (i_addr == OFS_DFIFO));
  wire h_awr   = i_wr & ~dack & (i_addr == OFS_AFIFO) & (mode_r == MODE_ECP);
  wire h_rd    = dma_rd | (i_rd & ~dack & (i_addr == OFS_DFIFO));
  wire fwd_ok  = fifo_md & (~dir_r | (mode_r == MODE_TEST));
  wire rev_ok  = fifo_md & (dir_r | (mode_r == MODE_TEST));
  wire rev_ecp = (mode_r == MODE_ECP) & dir_r;
  wire host_pu = (h_dwr | h_awr) & fwd_ok;
  // channel addresses dropped, run count latched
  wire rx_take = rx_edge & rev_ecp & (rep_n_r == 8'h00);
  wire rx_pu   = rx_take & ~rx_cmd & ~rle_p_r;
  wire rep_pu  = (rep_n_r != 8'h00);
  wire tx_pop  = (tx_st_r == TX_IDLE) & auto_md & ~dir_r & ~empty & ~busy;
  wire host_po = h_rd & rev_ok & ~empty;
  wire do_push = (host_pu | rx_pu | rep_pu) & ~full;
  wire do_pop  = tx_pop | host_po;
  wire [8:0] push_d = rep_pu ? {1'b0, rep_b_r} :
                      rx_pu  ? {1'b0, rx_data} : {h_awr, i_wdata};
  wire [8:0] head = mem_r[rp_r];

  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem_r[wp_r] <= push_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_r    <= 4'h0;
      rp_r    <= 4'h0;
      cnt_r   <= 5'h00;
      rle_n_r <= 7'h00;
      rle_p_r <= 1'b0;
      rep_n_r <= 8'h00;
      rep_b_r <= 8'h00;
    end else if (!fifo_md) begin
      wp_r    <= 4'h0;
      rp_r    <= 4'h0;
      cnt_r   <= 5'h00;
      rle_p_r <= 1'b0;
      rep_n_r <= 8'h00;
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 4'h1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 4'h1;
      end
      cnt_r <= cnt_r + {4'h0, do_push} - {4'h0, do_pop};
      if (rx_take && rx_cmd && !rx_data[RLE_BIT]) begin
        rle_n_r <= rx_data[6:0];
        rle_p_r <= 1'b1;
      end else if (rx_take && !rx_cmd && rle_p_r) begin
        rep_n_r <= {1'b0, rle_n_r} + 8'h01;
        rep_b_r <= rx_data;
        rle_p_r <= 1'b0;
      end else if (rep_pu && !full) begin
        rep_n_r <= rep_n_r - 8'h01;
      end
    end
  end

  // ***********************
  // Forward transmit handshake
  // ***********************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_r   <= TX_IDLE;
      o_tx_stb  <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_cmd  <= 1'b0;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          if (tx_pop) begin
            o_tx_data <= head[7:0];
            o_tx_cmd  <= head[8];
            o_tx_stb  <= 1'b1;
            tx_st_r   <= TX_WAIT_HI;
          end
        end
        TX_WAIT_HI: begin
          if (busy) begin
            o_tx_stb <= 1'b0;
            tx_st_r  <= TX_WAIT_LO;
          end
        end
        TX_WAIT_LO: begin
          if (!busy) begin
            tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ***********************
  // DMA request
  // ***********************
  logic [5:0] burst_r;
  logic [7:0] idle_r;
  logic       hold_r, tcb_r, svc_d_r;
  wire svc_fall = svc_d_r & ~svc_r;
  wire xfer     = dma_rd | dma_wr;
  wire idle_ok  = ({24'h0, idle_r} >= DACK_CYC);
  wire last_rd  = dma_rd & (cnt_r == 5'h01);
  wire last_wr  = dma_wr & (cnt_r == DEPTH_C - 5'h01);
  // reverse has data, forward has room
  wire drq_want = dir_r ? (~empty & ~last_rd) : (~full & ~last_wr);
  wire drq_nxt  = drq_want & dma_en_r & ~svc_r & auto_md & ~hold_r &
                  ~tcb_r & ~tc_ev & ~(xfer & (burst_r == BURST_MAX - 6'h01));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      burst_r <= 6'h00;
      idle_r  <= 8'h00;
      hold_r  <= 1'b0;
      tcb_r   <= 1'b0;
      svc_d_r <= 1'b1;
      o_drq   <= 1'b0;
    end else begin
      svc_d_r <= svc_r;
      o_drq   <= drq_nxt;
      idle_r  <= dack ? 8'h00 : (idle_ok ? idle_r : idle_r + 8'h01);
      if (hold_r && idle_ok) begin
        hold_r  <= 1'b0;
        burst_r <= 6'h00;
      end else if (xfer) begin
        burst_r <= burst_r + 6'h01;
        hold_r  <= hold_r | (burst_r == BURST_MAX - 6'h01);
      end else if (!o_drq && idle_ok) begin
        burst_r <= 6'h00;
      end
      if (tc & dack) begin
        tcb_r <= 1'b1;
      end else if (svc_fall) begin
        tcb_r <= 1'b0;
      end
    end
  end

  // ***********************
  // Interrupt events and pulse
  // ***********************
  logic       cond_d_r, errl_d_r;
  logic [3:0] irq_cnt_r;
  wire cond    = ~svc_r & ~dma_en_r & auto_md &
                 (dir_r ? (cnt_r >= lvl) : (free >= lvl));
  wire svc_ev  = cond & ~cond_d_r;
  wire err_ev  = (~errl_r & fault_f) | (errl_d_r & ~errl_r & fault);
  wire ack_ev  = acken_r & ack_r;
  wire irq_ev  = svc_ev | err_ev | ack_ev | tc_ev;
  wire [3:0] irq_nxt = irq_ev ? IRQ_CYC[3:0] :
                       (irq_cnt_r != 4'h0) ? irq_cnt_r - 4'h1 : 4'h0;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cond_d_r  <= 1'b0;
      errl_d_r  <= 1'b1;
      irq_cnt_r <= 4'h0;
      o_irq_oe  <= 1'b0;
      o_irq_o   <= 1'b0;
    end else begin
      cond_d_r  <= cond;
      errl_d_r  <= errl_r;
      irq_cnt_r <= irq_nxt;
      o_irq_oe  <= (irq_nxt != 4'h0);
      o_irq_o   <= 1'b0;
    end
  end

  // ***********************
  // Control pins and read data
  // ***********************
  wire       std_md = (mode_r == MODE_STD);
  wire [7:0] ecr_rd = {mode_r, errl_r, dma_en_r, svc_r, full, empty};
  wire [7:0] cfg_rd = {2'b00, acken_r, dir_r, thr_r};
  wire [7:0] rd_nxt = h_rd ? head[7:0] :
                      (i_rd && i_addr == OFS_ECR)  ? ecr_rd :
                      (i_rd && i_addr == OFS_CFG)  ? cfg_rd :
                      (i_rd && i_addr == OFS_PINS) ? {4'h0, pins_r} : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata  <= 8'h00;
      o_ctl_o  <= 4'h0;
      o_ctl_oe <= 4'h0;
    end else begin
      o_rdata  <= rd_nxt;
      o_ctl_o  <= std_md ? 4'h0 : pins_r;
      o_ctl_oe <= std_md ? ~pins_r : 4'hF;
    end
  end

  // ***********************
  // Checks
  // ***********************
  sequence s_tc_hit;
    tc_ev;
  endsequence
  property p_svc_block;
    @(posedge i_core_clk) disable iff (i_rst) svc_r |=> !o_drq;
  endproperty
  a_svc_block: assert property (p_svc_block) else $error("drq while disabled");
  property p_tc;
    @(posedge i_core_clk) disable iff (i_rst) s_tc_hit |=> svc_r && o_irq_oe;
  endproperty
  a_tc: assert property (p_tc) else $error("tc effects missing");
  property p_thr;
    @(posedge i_core_clk) disable iff (i_rst) thr_r == 4'hF |-> lvl == 5'h01;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold 16 not as 15");
  property p_burst;
    @(posedge i_core_clk) disable iff (i_rst) burst_r == BURST_MAX |-> !o_drq;
  endproperty
  a_burst: assert property (p_burst) else $error("burst over limit");
  property p_empty;
    @(posedge i_core_clk) disable iff (i_rst) dir_r && empty |=> !o_drq;
  endproperty
  a_empty: assert property (p_empty) else $error("drq on empty");
  property p_pulse;
    @(posedge i_core_clk) disable iff (i_rst)
      irq_ev |=> o_irq_oe && !o_irq_o ##10 !o_irq_oe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("irq pulse length");
  property p_reen;
    @(posedge i_core_clk) disable iff (i_rst)
      svc_fall && !cond_d_r && cond |=> o_irq_oe;
  endproperty
  a_reen: assert property (p_reen) else $error("no irq on re-enable");
  property p_oc;
    @(posedge i_core_clk) disable iff (i_rst)
      $past(std_md) && !$past(i_rst) |-> o_ctl_o == 4'h0;
  endproperty
  a_oc: assert property (p_oc) else $error("driven high in mode 000");
  property p_rle;
    @(posedge i_core_clk) disable iff (i_rst)
      fifo_md && rx_take && !rx_cmd && rle_p_r |=> rep_n_r == {1'b0, $past(rle_n_r)} + 8'h01;
  endproperty
  a_rle: assert property (p_rle) else $error("run count wrong");

endmodule : efsc_core

`default_nettype wire

// [hw/efsc_pkg.sv]
// Constants for the parallel port FIFO service block.
// Assumes a 250 MHz core clock and an 11-bit port offset.
package efsc_pkg;

  // ***********************
  // Port offsets
  // ***********************
  localparam int          AW         = 11;
  localparam logic [10:0] OFS_AFIFO  = 11'h000;
  localparam logic [10:0] OFS_PINS   = 11'h002;
  localparam logic [10:0] OFS_DFIFO  = 11'h400;
  localparam logic [10:0] OFS_ECR    = 11'h402;
  localparam logic [10:0] OFS_CFG    = 11'h403;

  // ***********************
  // Field layouts and reset values
  // ***********************
  localparam int         ECR_EMPTY  = 0;
  localparam int         ECR_FULL   = 1;
  localparam int         ECR_SVC    = 2;
  localparam int         ECR_DMA    = 3;
  localparam int         ECR_ERRL   = 4;
  localparam int         ECR_MODE   = 5;
  localparam int         CFG_DIR    = 4;
  localparam int         CFG_ACKEN  = 5;
  localparam int         RLE_BIT    = 7;
  localparam logic [2:0] MODE_STD   = 3'h0;
  localparam logic [2:0] MODE_FIFO  = 3'h2;
  localparam logic [2:0] MODE_ECP   = 3'h3;
  localparam logic [2:0] MODE_TEST  = 3'h6;
  localparam logic [3:0] PINS_RST   = 4'hF;
  localparam logic [3:0] THR_RST    = 4'h7;

  // ***********************
  // FIFO and timing
  // ***********************
  localparam int         DEPTH      = 16;
  localparam logic [4:0] DEPTH_C    = 5'h10;
  localparam logic [4:0] THR_CAP    = 5'h0F;
  localparam logic [5:0] BURST_MAX  = 6'h20;
  localparam int         CLK_NS     = 4;
  localparam int         DACK_NS    = 350;
  localparam int         DACK_CYC   = (DACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int         IRQ_NS     = 40;
  localparam int         IRQ_CYC    = IRQ_NS / CLK_NS;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT_HI, TX_WAIT_LO} efsc_tx_t;

endpackage : efsc_pkg

// [test/efsc_host_dma.sv]
// Host DMA controller model that answers the port's request and acknowledge pair.
// Assumes the port's clock; its read strobe is ORed with the bench's own.
`timescale 1ns/10ps
`default_nettype none

module efsc_host_dma (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_drq,
  input  wire logic [7:0] i_rdata,
  input  wire logic [7:0] i_exp,
  input  wire logic [8:0] i_tc_at,
  input  wire logic       i_slow,
  output logic            o_dack_n,
  output logic            o_rd,
  output logic            o_tc,
  output logic      [8:0] o_n_bytes,
  output logic      [8:0] o_n_bad
);
  logic [3:0] wait_r;
  logic       take_r;

  // ****************
  // Transfer engine
  // ****************
  // Gaps between strobes give the request time to fall, so no stray cycle is issued.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_r    <= 4'h0;
      take_r    <= 1'b0;
      o_dack_n  <= 1'b1;
      o_rd      <= 1'b0;
      o_tc      <= 1'b0;
      o_n_bytes <= 9'h000;
      o_n_bad   <= 9'h000;
    end else begin
      o_rd   <= 1'b0;
      o_tc   <= 1'b0;
      take_r <= o_rd;
      if (take_r) begin
        o_n_bytes <= o_n_bytes + 9'h001;
        o_n_bad   <= o_n_bad + {8'h00, i_rdata !== i_exp};
      end
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (i_drq !== 1'b1) begin
        o_dack_n <= 1'b1;
      end else if (o_dack_n) begin
        o_dack_n <= 1'b0;
        wait_r   <= 4'h3;
      end else begin
        o_rd   <= 1'b1;
        o_tc   <= (o_n_bytes + 9'h001 == i_tc_at);
        wait_r <= i_slow ? 4'h8 : 4'h2;
      end
    end
  end
endmodule : efsc_host_dma
`default_nettype wire

// [test/ecp_fifo_service_control_test.sv]
// Self-checking bench for the parallel port FIFO service block.
// Assumes the host DMA model file and one 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module ecp_fifo_service_control_test;
  import efsc_pkg::*;
  logic        clk, rst, wr_s, rd_s, dma_rd, dack_n, tc, drq, irq_o, irq_oe;
  logic        fault_n, ack_n, tx_cmd, tx_stb, tx_busy, rx_stb, rx_cmd, slow;
  logic        stb_q, drq_q, oe_q, short_gap;
  logic [10:0] addr;
  logic [7:0]  wdata, rdata, tx_data, rx_data, exp_b;
  logic [3:0]  ctl_o, ctl_oe;
  logic [8:0]  tc_at, n_bytes, n_bad;
  logic [8:0]  txq[$];
  int          n_mismatch, cmp_count, n_irq, mark, run, max_run, idle, w;

  efsc_core dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s | dma_rd), .o_rdata(rdata), .i_dack_n(dack_n), .i_tc(tc),
    .o_drq(drq), .o_irq_o(irq_o), .o_irq_oe(irq_oe), .i_fault_n(fault_n), .i_ack_n(ack_n),
    .o_ctl_o(ctl_o), .o_ctl_oe(ctl_oe), .o_tx_data(tx_data), .o_tx_cmd(tx_cmd),
    .o_tx_stb(tx_stb), .i_tx_busy(tx_busy), .i_rx_stb(rx_stb), .i_rx_cmd(rx_cmd),
    .i_rx_data(rx_data));
  efsc_host_dma host (.i_core_clk(clk), .i_rst(rst), .i_drq(drq), .i_rdata(rdata),
    .i_exp(exp_b), .i_tc_at(tc_at), .i_slow(slow), .o_dack_n(dack_n), .o_rd(dma_rd),
    .o_tc(tc), .o_n_bytes(n_bytes), .o_n_bad(n_bad));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e, "read");
  endtask : rd

  // The peripheral releases its data lines by driving the inverse after the hold time.
  task automatic rx(input logic c, input logic [7:0] d);
    @(posedge clk);
    rx_cmd  <= c;
    rx_data <= d;
    repeat (4) @(posedge clk);
    rx_stb  <= 1'b1;
    repeat (4) @(posedge clk);
    rx_stb  <= 1'b0;
    repeat (4) @(posedge clk);
    rx_data <= ~d;
  endtask : rx

  task automatic irq_chk(input int e);
    repeat (24) @(posedge clk);
    #1;
    chk(n_irq - mark, e, "irq events");
    mark = n_irq;
  endtask : irq_chk

  task automatic wait_bytes(input logic [8:0] n);
    int k;
    for (k = 0; k < 20000 && n_bytes !== n; k++) @(posedge clk);
    if (n_bytes !== n) begin
      n_mismatch++;
      $display("wrong value at %0t: DMA stalled", $time);
      stop_test();
    end
  endtask : wait_bytes

  // ****************
  // Peripheral and monitors
  // ****************
  // Busy answers the forward strobe one cycle later, so every byte completes.
  always @(posedge clk) begin
    tx_busy <= tx_stb;
    stb_q   <= tx_stb;
    if (tx_stb === 1'b1 && stb_q !== 1'b1) txq.push_back({tx_cmd, tx_data});
    oe_q <= irq_oe;
    if (irq_oe === 1'b1) w <= w + 1;
    if (irq_oe === 1'b1 && oe_q !== 1'b1) n_irq <= n_irq + 1;
    if (irq_oe !== 1'b1 && oe_q === 1'b1) begin
      chk(w, IRQ_CYC, "irq width");
      chk(irq_o, 1'b0, "irq level");
      w <= 0;
    end
    drq_q <= drq;
    if (dma_rd === 1'b1) run <= run + 1;
    idle <= (dack_n === 1'b1) ? idle + 1 : 0;
    if (drq === 1'b1 && drq_q !== 1'b1) begin
      if (run > max_run) max_run <= run;
      if (run == 32 && idle < DACK_CYC) short_gap <= 1'b1;
      run <= 0;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    int i;
    rst = 1'b1;
    {wr_s, rd_s, rx_stb, rx_cmd, slow, stb_q, drq_q, oe_q, short_gap} = '0;
    {fault_n, ack_n} = 2'h3;
    addr = 11'h000;
    wdata = 8'h00;
    rx_data = 8'h00;
    exp_b = 8'h3C;
    tc_at = 9'h080;
    {n_mismatch, cmp_count, n_irq, mark, run, max_run, idle, w} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_ECR, 8'h15);
    rd(OFS_CFG, 8'h07);
    rd(11'h123, 8'h00);
    chk(ctl_oe, 4'h0, "oe after reset");
    wr(OFS_PINS, 8'h05);
    repeat (3) @(posedge clk);
    #1;
    chk(ctl_oe, 4'hA, "open collector");
    $display("test reset and pins done");
    wr(OFS_CFG, 8'h27);
    @(posedge clk);
    ack_n <= 1'b0;
    irq_chk(0);
    @(posedge clk);
    ack_n <= 1'b1;
    irq_chk(1);
    @(posedge clk);
    fault_n <= 1'b0;
    irq_chk(0);
    wr(OFS_ECR, 8'h05);
    irq_chk(1);
    @(posedge clk);
    fault_n <= 1'b1;
    irq_chk(0);
    @(posedge clk);
    fault_n <= 1'b0;
    irq_chk(1);
    wr(OFS_CFG, 8'h07);
    $display("test pin interrupts done");
    wr(OFS_ECR, 8'hC4);
    for (i = 0; i < 17; i++) wr(OFS_DFIFO, 8'h10 + i[7:0]);
    rd(OFS_ECR, 8'hC6);
    for (i = 0; i < 16; i++) rd(OFS_DFIFO, 8'h10 + i[7:0]);
    rd(OFS_ECR, 8'hC5);
    wr(OFS_ECR, 8'h04);
    $display("test fifo depth done");
    wr(OFS_CFG, 8'h0F);
    wr(OFS_ECR, 8'h44);
    irq_chk(0);
    chk(ctl_oe, 4'hF, "push pull");
    wr(OFS_ECR, 8'h40);
    irq_chk(1);
    wr(OFS_DFIFO, 8'hC3);
    repeat (20) @(posedge clk);
    wr(OFS_ECR, 8'h04);
    wr(OFS_ECR, 8'h64);
    wr(OFS_AFIFO, 8'h05);
    wr(OFS_DFIFO, 8'h77);
    repeat (20) @(posedge clk);
    chk(txq.size(), 3, "sent bytes");
    chk(txq[0], 9'h0C3, "byte 0");
    chk(txq[1], 9'h105, "byte 1");
    chk(txq[2], 9'h077, "byte 2");
    wr(OFS_ECR, 8'h04);
    irq_chk(0);
    $display("test forward done");
    wr(OFS_CFG, 8'h1F);
    wr(OFS_ECR, 8'h64);
    wr(OFS_ECR, 8'h60);
    irq_chk(0);
    rx(1'b0, 8'h5A);
    irq_chk(1);
    wr(OFS_CFG, 8'h1D);
    rx(1'b0, 8'h5B);
    irq_chk(1);
    rx(1'b1, 8'h02);
    rx(1'b0, 8'hA5);
    rd(OFS_DFIFO, 8'h5A);
    rd(OFS_DFIFO, 8'h5B);
    for (i = 0; i < 3; i++) rd(OFS_DFIFO, 8'hA5);
    rd(OFS_ECR, 8'h61);
    irq_chk(0);
    wr(OFS_ECR, 8'h04);
    $display("test reverse done");
    wr(OFS_CFG, 8'h17);
    wr(OFS_ECR, 8'h64);
    wr(OFS_ECR, 8'h6C);
    wr(OFS_ECR, 8'h68);
    @(posedge clk);
    addr <= 11'h7FF;
    rx(1'b1, 8'h7F);
    rx(1'b0, 8'h3C);
    wait_bytes(9'h080);
    irq_chk(1);
    chk(drq, 1'b0, "request after count");
    chk(n_bad, 9'h000, "dma data");
    rd(OFS_ECR, 8'h6D);
    @(posedge clk);
    addr  <= 11'h7FF;
    exp_b <= 8'h11;
    tc_at <= 9'h081;
    slow  <= 1'b1;
    rx(1'b0, 8'h11);
    repeat (10) @(posedge clk);
    #1;
    chk(drq, 1'b0, "held after count");
    wr(OFS_ECR, 8'h68);
    @(posedge clk);
    addr <= 11'h7FF;
    wait_bytes(9'h081);
    irq_chk(1);
    chk(n_bad, 9'h000, "slow dma data");
    chk(max_run, 32, "longest burst");
    chk(short_gap, 1'b0, "burst gap");
    $display("test dma done");
    stop_test();
  end
endmodule : ecp_fifo_service_control_test
`default_nettype wire
